// >>> flash_host_params.svh
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// Register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_RDATA       8'h0C
// Control fields
`define CTRL_RESET_BIT  0
// Command fields
`define CMD_DATA_LSB    0
`define CMD_ADDR_LSB    8
`define CMD_WRITE_BIT   31
// Status fields
`define ST_BUSY_BIT     0
`define ST_RYBY_BIT     1
`define ST_TLIM_BIT     2
`define ST_EWIN_BIT     3
`define ST_TOG2_BIT     4
`define ST_TOG1_BIT     5
`define ST_POLL_BIT     6
`define ST_RSTDONE_BIT  7
// Timing
`define CLK_PERIOD_NS   20
`define RESET_LOW_NS    500
`define RESET_LOW_CYC   ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOV_US  20
`define RESET_RECOV_CYC ((`RESET_RECOV_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_W           16
`define BUS_PHASE_CYC   4
`define ADDR_W          21
`define SLV_OKAY        2'h0
`define SLV_DECERR      2'h3

`endif

// >>> flash_host_pkg.sv
package flash_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RST_LOW, ST_RST_WAIT
  } seq_state_e;

  typedef struct packed {
    logic        is_write;
    logic [20:0] addr;
    logic [7:0]  data;
  } flash_cmd_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
  } flash_ctl_s;
endpackage

// >>> flash_host.sv
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "flash_host_params.svh"
module flash_host (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Flash pins
  output logic [20:0]       flash_addr,
  input  wire logic [7:0]   flash_dq_in,
  output logic [7:0]        flash_dq_out,
  output logic              flash_dq_oe,
  output logic              flash_ce_n,
  output logic              flash_oe_n,
  output logic              flash_we_n,
  output logic              flash_reset_n,
  input  wire logic         ready_busy_n_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] dq_meta_q;
  logic [7:0] dq_sync_q;
  logic       ryby_meta_q;
  logic       ryby_sync_q;

  always_ff @(posedge aclk) begin
    dq_meta_q   <= flash_dq_in;
    dq_sync_q   <= dq_meta_q;
    ryby_meta_q <= ready_busy_n_out;
    ryby_sync_q <= ryby_meta_q;
  end

  // ****************************************
  // Bus decode
  // ****************************************
  logic         aw_held_q;
  logic [7:0]   aw_addr_q;
  logic         w_held_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         busy_q;
  logic         rst_done_q;
  logic         ctrl_reset_q;
  logic [7:0]   rdata_q;
  logic [7:0]   status_q;
  flash_host_pkg::seq_state_e state_q;

  wire do_write   = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_ctrl    = do_write && (aw_addr_q == `REG_CTRL);
  wire wr_cmd     = do_write && (aw_addr_q == `REG_CMD);
  wire wr_mapped  = wr_ctrl || wr_cmd;
  // Commands arriving while a cycle runs are dropped, not queued
  wire cmd_go     = wr_cmd && !busy_q && w_strb_q == 4'hF;
  wire rd_go      = s_axi_arvalid && s_axi_arready;
  wire rd_ctrl    = s_axi_araddr == `REG_CTRL;
  wire rd_status  = s_axi_araddr == `REG_STATUS;
  wire rd_rdata   = s_axi_araddr == `REG_RDATA;
  wire rd_mapped  = rd_ctrl || rd_status || rd_rdata;
  wire [31:0] rd_word = rd_ctrl   ? {31'h0, ctrl_reset_q} :
                        rd_status ? {24'h0, status_q} :
                        rd_rdata  ? {24'h0, rdata_q} : 32'h0;
  wire reset_req  = wr_ctrl && w_data_q[`CTRL_RESET_BIT] && !busy_q;
  wire aw_take    = s_axi_awvalid && s_axi_awready;
  wire w_take     = s_axi_wvalid && s_axi_wready;
  wire aw_held_d  = aw_take || (aw_held_q && !do_write);
  wire w_held_d   = w_take || (w_held_q && !do_write);
  wire bvalid_d   = do_write || (s_axi_bvalid && !s_axi_bready);
  wire rvalid_d   = rd_go || (s_axi_rvalid && !s_axi_rready);

  flash_host_pkg::flash_cmd_s cmd_q;
  wire flash_host_pkg::flash_cmd_s cmd_new = '{
    is_write: w_data_q[`CMD_WRITE_BIT],
    addr:     w_data_q[`CMD_ADDR_LSB +: `ADDR_W],
    data:     w_data_q[`CMD_DATA_LSB +: 8]
  };

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_held_q      <= 1'b0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SLV_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SLV_OKAY;
    end else begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready  <= !w_held_d && !bvalid_d;
      s_axi_arready <= !rvalid_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `SLV_OKAY : `SLV_DECERR;
      end
      if (rd_go) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `SLV_OKAY : `SLV_DECERR;
      end
    end
  end

  // ****************************************
  // Flash bus sequencer
  // ****************************************
  logic [`CYC_W-1:0] cnt_q;
  flash_host_pkg::flash_ctl_s ctl_q;
  logic [7:0] dq_out_q;
  logic       dq_oe_q;

  wire cnt_done = cnt_q == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= flash_host_pkg::ST_IDLE;
      cnt_q        <= '0;
      busy_q       <= 1'b0;
      cmd_q        <= '0;
      // Pins idle: deselected, no strobes, no drive
      ctl_q        <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1};
      dq_out_q     <= 8'h00;
      dq_oe_q      <= 1'b0;
      rdata_q      <= 8'h00;
      rst_done_q   <= 1'b0;
      ctrl_reset_q <= 1'b0;
    end else begin
      case (state_q)
        flash_host_pkg::ST_IDLE: begin
          if (reset_req) begin
            // Reset pulse covers the minimum low time
            state_q      <= flash_host_pkg::ST_RST_LOW;
            cnt_q        <= `CYC_W'(`RESET_LOW_CYC - 1);
            busy_q       <= 1'b1;
            rst_done_q   <= 1'b0;
            ctrl_reset_q <= 1'b1;
            ctl_q.reset_n <= 1'b0;
            dq_oe_q      <= 1'b0;
          end else if (cmd_go) begin
            state_q <= flash_host_pkg::ST_SETUP;
            cnt_q   <= `CYC_W'(`BUS_PHASE_CYC - 1);
            busy_q  <= 1'b1;
            cmd_q   <= cmd_new;
            ctl_q.ce_n <= 1'b0;
            // Output enable stays high through any write
            ctl_q.oe_n <= 1'b1;
            dq_out_q   <= cmd_new.data;
            dq_oe_q    <= cmd_new.is_write;
          end
        end
        flash_host_pkg::ST_SETUP: begin
          if (cnt_done) begin
            state_q <= flash_host_pkg::ST_STROBE;
            cnt_q   <= `CYC_W'(`BUS_PHASE_CYC - 1);
            // Write only with chip enable low, output enable high
            ctl_q.we_n <= !cmd_q.is_write;
            ctl_q.oe_n <= cmd_q.is_write;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        flash_host_pkg::ST_STROBE: begin
          if (cnt_done) begin
            state_q <= flash_host_pkg::ST_HOLD;
            cnt_q   <= `CYC_W'(`BUS_PHASE_CYC - 1);
            ctl_q.we_n <= 1'b1;
            ctl_q.oe_n <= 1'b1;
            // Each read ends with OE high so toggle bits advance
            if (!cmd_q.is_write) begin
              rdata_q <= dq_sync_q;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        flash_host_pkg::ST_HOLD: begin
          if (cnt_done) begin
            state_q    <= flash_host_pkg::ST_IDLE;
            busy_q     <= 1'b0;
            ctl_q.ce_n <= 1'b1;
            dq_oe_q    <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        flash_host_pkg::ST_RST_LOW: begin
          if (cnt_done) begin
            state_q <= flash_host_pkg::ST_RST_WAIT;
            cnt_q   <= `CYC_W'(`RESET_RECOV_CYC - `RESET_LOW_CYC - 1);
            ctl_q.reset_n <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        flash_host_pkg::ST_RST_WAIT: begin
          // Wait out the internal reset before the next access
          if (cnt_done) begin
            state_q      <= flash_host_pkg::ST_IDLE;
            busy_q       <= 1'b0;
            rst_done_q   <= 1'b1;
            ctrl_reset_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= flash_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Status view
  // ****************************************
  // Bits 2-6 decoded from the last read byte; software judges the mode
  // from two successive reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 8'h00;
    end else begin
      status_q[`ST_BUSY_BIT]    <= busy_q;
      status_q[`ST_RYBY_BIT]    <= ryby_sync_q;
      status_q[`ST_TLIM_BIT]    <= rdata_q[5];
      status_q[`ST_EWIN_BIT]    <= rdata_q[3];
      status_q[`ST_TOG2_BIT]    <= rdata_q[2];
      status_q[`ST_TOG1_BIT]    <= rdata_q[6];
      status_q[`ST_POLL_BIT]    <= rdata_q[7];
      status_q[`ST_RSTDONE_BIT] <= rst_done_q;
    end
  end

  assign flash_addr    = cmd_q.addr;
  assign flash_dq_out  = dq_out_q;
  assign flash_dq_oe   = dq_oe_q;
  assign flash_ce_n    = ctl_q.ce_n;
  assign flash_oe_n    = ctl_q.oe_n;
  assign flash_we_n    = ctl_q.we_n;
  assign flash_reset_n = ctl_q.reset_n;

endmodule

// >>> flash_host_props.sv
`timescale 1ns/1ns
`include "flash_host_params.svh"
module flash_host_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n
);
  // ******************
  // Properties
  // ******************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] lo_q;
  // Saturates so a stuck reset cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || flash_reset_n) begin
      lo_q <= 8'h00;
    end else if (lo_q != 8'hFF) begin
      lo_q <= lo_q + 8'h01;
    end
  end
  sequence s_we_fall;
    $fell(flash_we_n);
  endsequence
  property p_idle;
    $rose(aresetn) |-> flash_ce_n && flash_we_n && flash_oe_n && flash_reset_n && !flash_dq_oe;
  endproperty
  property p_wr_gate;
    !flash_we_n |-> !flash_ce_n && flash_oe_n;
  endproperty
  property p_no_fight;
    flash_dq_oe |-> flash_oe_n;
  endproperty
  property p_rst_len;
    $rose(flash_reset_n) |-> lo_q >= 8'(`RESET_LOW_CYC);
  endproperty
  property p_we_pulse;
    s_we_fall |-> (!flash_ce_n throughout !flash_we_n [*4]);
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_idle: assert property (p_idle) else $error("pins not idle");
  a_wr_gate: assert property (p_wr_gate) else $error("bad write gate");
  a_no_fight: assert property (p_no_fight) else $error("bus contention");
  a_rst_len: assert property (p_rst_len) else $error("reset too short");
  a_we_pulse: assert property (p_we_pulse) else $error("short strobe");
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  a_bdone: assert property (p_bdone) else $error("bvalid repeated");
endmodule

// >>> flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model (
  // Busy timer clock
  input wire logic clk,
  // Device pins
  input wire logic [20:0] addr,
  input wire logic [7:0]  dq_in,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        reset_n,
  output logic [7:0]      dq,
  output logic            rb_low
);
  // ******************
  // Device behaviour
  // ******************
  logic [7:0] mem [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h0F};
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [1:0] pa = 2'h0;
  logic [2:0] wc = 3'h0;
  logic       tog = 1'b0;
  logic       tog2 = 1'b0;
  logic       er = 1'b0;
  int         busy = 0;
  // Erase window closes 100 cycles into a 400 cycle erase
  wire        ewin = busy <= 300;
  always @(posedge we_n) begin
    if (!ce_n && oe_n && reset_n && busy == 0) begin
      wc = wc + 3'h1;
      if (wc == 3'h4 && dq_in != 8'h80) begin
        pa = addr[1:0];
        pd = dq_in;
        busy = 150;
        wc = 3'h0;
      end else if (wc == 3'h6) begin
        er = 1'b1;
        busy = 400;
        wc = 3'h0;
      end
    end
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      busy = 0;
      er = 1'b0;
      wc = 3'h0;
    end else if (busy == 1) begin
      if (er) begin
        foreach (mem[i]) mem[i] = 8'hFF;
      end else begin
        mem[pa] = mem[pa] & pd;
      end
      er = 1'b0;
      busy = 0;
    end else if (busy > 1) begin
      busy = busy - 1;
    end
  end
  always @(negedge oe_n) begin
    if (!ce_n && busy != 0) begin
      tog = ~tog;
      tog2 = tog2 ^ er;
    end
  end
  always @(negedge clk) begin
    if (!oe_n && !ce_n) last = dq;
  end
  assign rb_low = busy != 0 || !reset_n;
  // Released bus shows the inverse of its last value, not a kind constant
  assign dq = (!ce_n && !oe_n && reset_n) ?
              (busy == 0 ? mem[addr[1:0]] :
               er ? {1'b0, tog, 2'h0, ewin, tog2, 2'h0} :
               {~pd[7], tog, 6'h04}) : ~last;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
`include "flash_host_params.svh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, t1;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [20:0] faddr;
  logic [7:0]  dq_out, dq_dev, dq_in;
  logic        dq_oe, ce_n, oe_n, we_n, frst_n, rb_low, rb_n;
  int          n_mismatch = 0;
  int          checks = 0;
  always #10 aclk = ~aclk;
  // Pull-up on ready/busy; host drive wins the data wire
  assign rb_n = ~rb_low;
  assign dq_in = dq_oe ? dq_out : dq_dev;
  flash_host flash_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(frst_n), .ready_busy_n_out(rb_n));
  flash_dev_model flash_dev_model_inst (.clk(aclk), .addr(faddr), .dq_in(dq_out), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .reset_n(frst_n), .dq(dq_dev), .rb_low(rb_low));
  // ******************
  // Tasks
  // ******************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    int   n;
    {tb, n} = '0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, v};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!tb && n < 100) begin
      @(negedge aclk);
      {ta, tw, tb, rs} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!tb) chk(32'h0, 32'h1);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tb;
    int   n;
    {tb, n} = '0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!tb && n < 100) begin
      @(negedge aclk);
      {ta, tb, v, rs} = {arvalid && arready, rvalid && rready, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!tb) chk(32'h0, 32'h1);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] x;
    logic [1:0]  rs;
    int          n = 0;
    do begin
      axi_rd(a, x, rs);
      n++;
    end while (x[b] !== v && n < 500);
    chk({31'h0, x[b]}, {31'h0, v});
  endtask
  task automatic fcmd(input logic w, input logic [20:0] a, input logic [7:0] v);
    axi_wr(`REG_CMD, {w, 2'h0, a, v}, r);
    chk({30'h0, r}, {30'h0, `SLV_OKAY});
    wait_bit(`REG_STATUS, `ST_BUSY_BIT, 1'b0);
    if (!w) axi_rd(`REG_RDATA, d, r);
  endtask
  task automatic results;
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ******************
  // Tests
  // ******************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(8'h20, 32'h0, r);
    chk({30'h0, r}, {30'h0, `SLV_DECERR});
    axi_rd(8'h20, d, r);
    chk({30'h0, r}, {30'h0, `SLV_DECERR});
    fcmd(1'b0, 21'h1, 8'h00);
    chk({24'h0, d[7:0]}, 32'h3C);
    for (int i = 0; i < 3; i++) fcmd(1'b1, 21'(i), 8'hAA);
    axi_rd(`REG_STATUS, d, r);
    chk({31'h0, d[`ST_RYBY_BIT]}, 32'h1);
    fcmd(1'b1, 21'h2, 8'h5A);
    axi_rd(`REG_STATUS, d, r);
    chk({31'h0, d[`ST_RYBY_BIT]}, 32'h0);
    fcmd(1'b0, 21'h2, 8'h00);
    chk(d & 32'hA4, 32'h84);
    t1 = d[6];
    fcmd(1'b0, 21'h2, 8'h00);
    chk({31'h0, d[6]}, {31'h0, ~t1});
    wait_bit(`REG_STATUS, `ST_RYBY_BIT, 1'b1);
    fcmd(1'b0, 21'h2, 8'h00);
    chk({24'h0, d[7:0]}, 32'h5A);
    for (int i = 0; i < 4; i++) fcmd(1'b1, 21'h3, 8'h00);
    wait_bit(`REG_STATUS, `ST_RYBY_BIT, 1'b1);
    for (int i = 0; i < 6; i++) fcmd(1'b1, 21'h4, (i == 3) ? 8'h80 : 8'h30);
    fcmd(1'b0, 21'h4, 8'h00);
    chk(d & 32'h88, 32'h0);
    t1 = d[2];
    fcmd(1'b0, 21'h4, 8'h00);
    chk({31'h0, d[2]}, {31'h0, ~t1});
    repeat (100) @(posedge aclk);
    fcmd(1'b0, 21'h4, 8'h00);
    chk(d & 32'h88, 32'h08);
    axi_wr(`REG_CTRL, 32'h1, r);
    axi_rd(`REG_STATUS, d, r);
    chk({31'h0, d[`ST_RYBY_BIT]}, 32'h0);
    axi_rd(`REG_CTRL, d, r);
    chk({31'h0, d[0]}, 32'h1);
    wait_bit(`REG_CTRL, 0, 1'b0);
    axi_rd(`REG_STATUS, d, r);
    chk(d & 32'h83, 32'h82);
    fcmd(1'b0, 21'h0, 8'h00);
    chk({24'h0, d[7:0]}, 32'hA5);
    results;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results;
  end
endmodule
bind flash_host flash_host_props flash_host_props_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n));
